// [hw/lrpfs_regs.vh]
// Register map, field positions, reset values and timing counts of the run-permit fault supervisor
`ifndef LRPFS_REGS_VH
`define LRPFS_REGS_VH

// Byte offsets of the register words
`define LRPFS_ADDR_W          5
`define LRPFS_OFF_CTRL        5'h00
`define LRPFS_OFF_STATUS      5'h04
`define LRPFS_OFF_IRQ_STAT    5'h08
`define LRPFS_OFF_IRQ_CLR     5'h0C
`define LRPFS_OFF_IRQ_EN      5'h10
`define LRPFS_OFF_PW_LIMIT    5'h14
`define LRPFS_OFF_DUTY_LIMIT  5'h18

// Control word fields and reset value
`define LRPFS_CTRL_LASER_EN   0
`define LRPFS_CTRL_RST        1'h1

// Status word fields
`define LRPFS_ST_LASER_ON     0
`define LRPFS_ST_DUTY_EXCESS  1
`define LRPFS_ST_REFL_EXCESS  2
`define LRPFS_ST_TEMP_LATCH   3
`define LRPFS_ST_SHUT_LATCH   4
`define LRPFS_ST_TERMINAL     5
`define LRPFS_ST_SYS_FAULT    6
`define LRPFS_ST_PERMIT       7
`define LRPFS_ST_CHECK_DONE   8
`define LRPFS_ST_W            9

// Interrupt event bits
`define LRPFS_IRQ_DUTY        0
`define LRPFS_IRQ_REFL        1
`define LRPFS_IRQ_LATCH       2
`define LRPFS_IRQ_TERMINAL    3
`define LRPFS_IRQ_CLEARED     4
`define LRPFS_IRQ_W           5
`define LRPFS_IRQ_EN_RST      5'h00

// Pulse width and duty limits, in clock cycles
`define LRPFS_LIM_W           16
`define LRPFS_PW_LIMIT_RST    16'h2710
`define LRPFS_WIN_W           10
`define LRPFS_WIN_LAST        10'h3FF
`define LRPFS_DUTY_LIMIT_RST  16'h0200

// Timing: clock period and power-up fault check time
`define LRPFS_CLK_PERIOD_NS   20
`define LRPFS_TERM_CHECK_NS   320
`define LRPFS_TERM_CNT_W      8

`endif

// [hw/lrpfs_supervisor.v]
// Run-permit, modulation gating and fault supervisor with Avalon-MM register slave
`timescale 1ns/1ps
`include "lrpfs_regs.vh"

module lrpfs_supervisor (
    input  wire                       clk,
    input  wire                       arst_n,
    // Real-time port pins
    input  wire                       modIn,
    input  wire                       permitIn,
    // Fault sensor pins
    input  wire                       tempFaultIn,
    input  wire                       shutterFaultIn,
    input  wire                       reflOverIn,
    input  wire                       terminalFaultIn,
    // Real-time port outputs
    output wire                       laserOut,
    output wire                       sysFault,
    output wire                       dutyExcessFlag,
    output wire                       reflectionExcessFlag,
    output wire                       tempFaultFlag,
    output wire                       shutterFaultFlag,
    output wire                       irq,
    // Avalon-MM slave
    input  wire [`LRPFS_ADDR_W-1:0]   avs_address,
    input  wire                       avs_read,
    input  wire                       avs_write,
    input  wire [31:0]                avs_writedata,
    output wire [31:0]                avs_readdata,
    output wire                       avs_waitrequest
);

    // Power-up check length in cycles, rounded up; cut to the counter width on purpose
    localparam integer TERM_CHECK_INT =
        (`LRPFS_TERM_CHECK_NS + `LRPFS_CLK_PERIOD_NS - 1) / `LRPFS_CLK_PERIOD_NS;
    localparam [`LRPFS_TERM_CNT_W-1:0] TERM_CHECK_CYC = TERM_CHECK_INT[`LRPFS_TERM_CNT_W-1:0];

    localparam NSYNC = 6;
    localparam SI_MOD = 0;
    localparam SI_PERMIT = 1;
    localparam SI_TEMP = 2;
    localparam SI_SHUT = 3;
    localparam SI_REFL = 4;
    localparam SI_TERM = 5;

    reg  [NSYNC-1:0]              syncA_ff;
    reg  [NSYNC-1:0]              syncB_ff;
    reg                           permitD_ff;
    reg  [`LRPFS_TERM_CNT_W-1:0]  termCnt_ff;
    reg                           checkDone_ff;
    reg                           terminal_ff;
    reg                           tempLatch_ff;
    reg                           shutLatch_ff;
    reg                           sysFault_ff;
    reg                           laserOut_ff;
    reg                           dutyFlag_ff;
    reg                           reflFlag_ff;
    reg  [`LRPFS_LIM_W-1:0]       pwCnt_ff;
    reg  [`LRPFS_WIN_W-1:0]       winCnt_ff;
    reg  [`LRPFS_LIM_W-1:0]       onCnt_ff;
    reg                           ctrlLaserEn_ff;
    reg  [`LRPFS_LIM_W-1:0]       pwLimit_ff;
    reg  [`LRPFS_LIM_W-1:0]       dutyLimit_ff;
    reg  [`LRPFS_IRQ_W-1:0]       irqStat_ff;
    reg  [`LRPFS_IRQ_W-1:0]       irqEn_ff;
    reg                           ack_ff;
    reg  [31:0]                   rdData_ff;
    reg  [31:0]                   nxt_rdData;
    reg  [`LRPFS_IRQ_W-1:0]       nxt_irqStat;

    wire modS;
    wire permitS;
    wire tempS;
    wire shutS;
    wire reflS;
    wire termS;
    wire permitRise;
    wire causeGone;
    wire clearLatch;
    wire nxt_tempLatch;
    wire nxt_shutLatch;
    wire nxt_terminal;
    wire anyLatch;
    wire runAllowed;
    wire commanded;
    wire pulseTooLong;
    wire dutyOver;
    wire dutyInhibit;
    wire nxt_laserOut;
    wire nxt_dutyFlag;
    wire nxt_reflFlag;
    wire [`LRPFS_ST_W-1:0] statusWord;
    wire [`LRPFS_IRQ_W-1:0] irqEvents;
    wire busReq;
    wire wrStb;

    // Pin synchroniser
    // Two flops on every pin; only the second stage is read by logic
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_ff <= {NSYNC{1'b0}};
            syncB_ff <= {NSYNC{1'b0}};
        end else begin
            syncA_ff <= {terminalFaultIn, reflOverIn, shutterFaultIn, tempFaultIn, permitIn, modIn};
            syncB_ff <= syncA_ff;
        end
    end

    assign modS    = syncB_ff[SI_MOD];
    assign permitS = syncB_ff[SI_PERMIT];
    assign tempS   = syncB_ff[SI_TEMP];
    assign shutS   = syncB_ff[SI_SHUT];
    assign reflS   = syncB_ff[SI_REFL];
    assign termS   = syncB_ff[SI_TERM];

    // Toggle detection
    // Permit reset value 0 means a permit held high through reset needs no toggle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            permitD_ff <= 1'b0;
        end else begin
            permitD_ff <= permitS;
        end
    end

    assign permitRise = permitS & ~permitD_ff;

    // Power-up terminal check
    // Sensor is sampled once the check time after reset release has elapsed
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            termCnt_ff   <= {`LRPFS_TERM_CNT_W{1'b0}};
            checkDone_ff <= 1'b0;
            terminal_ff  <= 1'b0;
        end else begin
            if (!checkDone_ff) begin
                termCnt_ff <= termCnt_ff + {{(`LRPFS_TERM_CNT_W-1){1'b0}}, 1'b1};
            end
            if (!checkDone_ff && (termCnt_ff == TERM_CHECK_CYC - 1'b1)) begin
                checkDone_ff <= 1'b1;
            end
            terminal_ff <= nxt_terminal;
        end
    end

    // Terminal latch held until device reset
    assign nxt_terminal = terminal_ff |
                          (~checkDone_ff & (termCnt_ff == TERM_CHECK_CYC - 1'b1) & termS);

    // Guarded fault clear
    // A toggle is ignored while either cause is still present
    assign causeGone  = ~tempS & ~shutS;
    assign clearLatch = permitRise & causeGone;

    // Latching fault capture
    // Set terms come last so a fault in the clear cycle wins
    assign nxt_tempLatch = (tempLatch_ff & ~clearLatch) | tempS;
    assign nxt_shutLatch = (shutLatch_ff & ~clearLatch) | shutS;
    assign anyLatch      = tempLatch_ff | shutLatch_ff;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tempLatch_ff <= 1'b0;
            shutLatch_ff <= 1'b0;
        end else begin
            tempLatch_ff <= nxt_tempLatch;
            shutLatch_ff <= nxt_shutLatch;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sysFault_ff <= 1'b0;
        end else begin
            sysFault_ff <= nxt_terminal | nxt_tempLatch | nxt_shutLatch;
        end
    end

    // Latched fault blocks operation
    // Raw fault sensors gate too, so shutdown does not wait for the latch flop
    assign runAllowed = permitS & checkDone_ff & ~terminal_ff & ~anyLatch &
                        ~tempS & ~shutS & ctrlLaserEn_ff;
    assign commanded  = modS & runAllowed;

    // Pulse width and duty measurement
    // Duty is judged per fixed window of clock cycles; coarse but cheap and bounded
    assign pulseTooLong = (pwCnt_ff >= pwLimit_ff);
    assign dutyOver     = (onCnt_ff >= dutyLimit_ff);
    assign dutyInhibit  = pulseTooLong | dutyOver;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwCnt_ff  <= {`LRPFS_LIM_W{1'b0}};
            winCnt_ff <= {`LRPFS_WIN_W{1'b0}};
            onCnt_ff  <= {`LRPFS_LIM_W{1'b0}};
        end else begin
            if (!modS) begin
                pwCnt_ff <= {`LRPFS_LIM_W{1'b0}};
            end else if (!pulseTooLong) begin
                pwCnt_ff <= pwCnt_ff + {{(`LRPFS_LIM_W-1){1'b0}}, 1'b1};
            end
            winCnt_ff <= winCnt_ff + {{(`LRPFS_WIN_W-1){1'b0}}, 1'b1};
            if (winCnt_ff == `LRPFS_WIN_LAST) begin
                onCnt_ff <= {`LRPFS_LIM_W{1'b0}};
            end else if (nxt_laserOut && !dutyOver) begin
                onCnt_ff <= onCnt_ff + {{(`LRPFS_LIM_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign nxt_laserOut = commanded & ~dutyInhibit & ~reflS;
    // Duty flag only in violating part
    assign nxt_dutyFlag = commanded & dutyInhibit;
    assign nxt_reflFlag = commanded & reflS;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            laserOut_ff <= 1'b0;
            dutyFlag_ff <= 1'b0;
            reflFlag_ff <= 1'b0;
        end else begin
            laserOut_ff <= nxt_laserOut;
            dutyFlag_ff <= nxt_dutyFlag;
            reflFlag_ff <= nxt_reflFlag;
        end
    end

    assign laserOut             = laserOut_ff;
    assign sysFault             = sysFault_ff;
    assign dutyExcessFlag       = dutyFlag_ff;
    assign reflectionExcessFlag = reflFlag_ff;
    assign tempFaultFlag        = tempLatch_ff;
    assign shutterFaultFlag     = shutLatch_ff;

    // Status word seen by software
    assign statusWord = {checkDone_ff, permitS, sysFault_ff, terminal_ff, shutLatch_ff,
                         tempLatch_ff, reflFlag_ff, dutyFlag_ff, laserOut_ff};

    // Event reporting
    // Rising edges of flags and latches, plus the clearing of both latches, are the interrupt events
    assign irqEvents[`LRPFS_IRQ_DUTY]     = nxt_dutyFlag & ~dutyFlag_ff;
    assign irqEvents[`LRPFS_IRQ_REFL]     = nxt_reflFlag & ~reflFlag_ff;
    assign irqEvents[`LRPFS_IRQ_LATCH]    = (nxt_tempLatch & ~tempLatch_ff) | (nxt_shutLatch & ~shutLatch_ff);
    assign irqEvents[`LRPFS_IRQ_TERMINAL] = nxt_terminal & ~terminal_ff;
    assign irqEvents[`LRPFS_IRQ_CLEARED]  = anyLatch & ~nxt_tempLatch & ~nxt_shutLatch;

    // Bus handshake: one wait cycle, access completes at the edge with waitrequest low
    assign busReq          = avs_read | avs_write;
    assign avs_waitrequest = busReq & ~ack_ff;
    assign wrStb           = avs_write & ack_ff;

    // Sticky interrupt status; a new event beats a clear in the same cycle
    always @* begin
        nxt_irqStat = irqStat_ff;
        if (wrStb && (avs_address == `LRPFS_OFF_IRQ_CLR)) begin
            nxt_irqStat = irqStat_ff & ~avs_writedata[`LRPFS_IRQ_W-1:0];
        end
        nxt_irqStat = nxt_irqStat | irqEvents;
    end

    assign irq = |(irqStat_ff & irqEn_ff);

    // Read mux; unmapped and write-only words read as zero
    always @* begin
        nxt_rdData = 32'h00000000;
        case (avs_address)
            `LRPFS_OFF_CTRL: begin
                nxt_rdData[`LRPFS_CTRL_LASER_EN] = ctrlLaserEn_ff;
            end
            `LRPFS_OFF_STATUS: begin
                nxt_rdData[`LRPFS_ST_W-1:0] = statusWord;
            end
            `LRPFS_OFF_IRQ_STAT: begin
                nxt_rdData[`LRPFS_IRQ_W-1:0] = irqStat_ff;
            end
            `LRPFS_OFF_IRQ_EN: begin
                nxt_rdData[`LRPFS_IRQ_W-1:0] = irqEn_ff;
            end
            `LRPFS_OFF_PW_LIMIT: begin
                nxt_rdData[`LRPFS_LIM_W-1:0] = pwLimit_ff;
            end
            `LRPFS_OFF_DUTY_LIMIT: begin
                nxt_rdData[`LRPFS_LIM_W-1:0] = dutyLimit_ff;
            end
            default: begin
                nxt_rdData = 32'h00000000;
            end
        endcase
    end

    // Bus slave registers; read data is captured in the wait cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff         <= 1'b0;
            rdData_ff      <= 32'h00000000;
            ctrlLaserEn_ff <= `LRPFS_CTRL_RST;
            pwLimit_ff     <= `LRPFS_PW_LIMIT_RST;
            dutyLimit_ff   <= `LRPFS_DUTY_LIMIT_RST;
            irqEn_ff       <= `LRPFS_IRQ_EN_RST;
            irqStat_ff     <= {`LRPFS_IRQ_W{1'b0}};
        end else begin
            ack_ff     <= busReq & ~ack_ff;
            irqStat_ff <= nxt_irqStat;
            if (avs_read && !ack_ff) begin
                rdData_ff <= nxt_rdData;
            end
            if (wrStb) begin
                case (avs_address)
                    `LRPFS_OFF_CTRL: begin
                        ctrlLaserEn_ff <= avs_writedata[`LRPFS_CTRL_LASER_EN];
                    end
                    `LRPFS_OFF_IRQ_EN: begin
                        irqEn_ff <= avs_writedata[`LRPFS_IRQ_W-1:0];
                    end
                    `LRPFS_OFF_PW_LIMIT: begin
                        pwLimit_ff <= avs_writedata[`LRPFS_LIM_W-1:0];
                    end
                    `LRPFS_OFF_DUTY_LIMIT: begin
                        dutyLimit_ff <= avs_writedata[`LRPFS_LIM_W-1:0];
                    end
                    default: begin
                        ctrlLaserEn_ff <= ctrlLaserEn_ff;
                    end
                endcase
            end
        end
    end

    assign avs_readdata = rdData_ff;

endmodule // lrpfs_supervisor

// [sim/lrpfs_supervisor_sva.sv]
// Port assertions of the run-permit fault supervisor
`timescale 1ns/1ps
module lrpfs_supervisor_sva (
    input logic clk,
    input logic arst_n,
    input logic modIn,
    input logic permitIn,
    input logic tempFaultIn,
    input logic shutterFaultIn,
    input logic reflOverIn,
    input logic laserOut,
    input logic sysFault,
    input logic dutyExcessFlag,
    input logic reflectionExcessFlag,
    input logic tempFaultFlag,
    input logic shutterFaultFlag,
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest
);
    // Pins take two sync flops plus one output flop, so causes sit three edges back
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    laser_gate_a: assert property (laserOut |-> $past(modIn, 3) && $past(permitIn, 3))
        else $error("laser on without command or permit");
    raw_fault_a: assert property (laserOut |-> !$past(tempFaultIn, 3) && !$past(shutterFaultIn, 3))
        else $error("laser on while a latching cause is present");
    temp_latch_a: assert property (tempFaultIn |-> ##3 (tempFaultFlag && sysFault && !laserOut))
        else $error("temperature fault not latched in time");
    shutter_latch_a: assert property (shutterFaultIn |-> ##3 (shutterFaultFlag && sysFault && !laserOut))
        else $error("shutter fault not latched in time");
    latch_hold_a: assert property ((tempFaultFlag || shutterFaultFlag) |-> sysFault && !laserOut)
        else $error("latched fault without summary fault or with laser on");
    latch_clear_a: assert property (($fell(tempFaultFlag) || $fell(shutterFaultFlag))
        |-> $past(permitIn, 3) && !$past(permitIn, 4) && !$past(tempFaultIn, 3) && !$past(shutterFaultIn, 3))
        else $error("latch cleared without a clean permit toggle");
    duty_flag_a: assert property (dutyExcessFlag |-> $past(modIn, 3) && !laserOut)
        else $error("duty flag outside an inhibited pulse");
    refl_flag_a: assert property (reflectionExcessFlag |-> $past(modIn, 3) && $past(reflOverIn, 3) && !laserOut)
        else $error("reflection flag outside an inhibited pulse");
    bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access not answered after one wait cycle");
endmodule // lrpfs_supervisor_sva

// [sim/lrpfs_ctrl_model.sv]
// Machine controller model driving modulation and run permit
`timescale 1ns/1ps
module lrpfs_ctrl_model (
    input  logic clk,
    output logic modIn,
    output logic permitIn
);
    initial begin
        modIn = 1'b0;
        permitIn = 1'b1;
    end

    // one pulse of w cycles; tail lets the three-edge pipeline drain
    task automatic pulse(input int w);
        @(posedge clk);
        modIn <= 1'b1;
        repeat (w) @(posedge clk);
        modIn <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // permit level held long enough to pass the synchroniser
    task automatic set_permit(input logic v);
        @(posedge clk);
        permitIn <= v;
        repeat (5) @(posedge clk);
    endtask

    // fault clear is permit low then high again
    task automatic toggle();
        set_permit(1'b0);
        set_permit(1'b1);
    endtask
endmodule // lrpfs_ctrl_model

// [sim/lrpfs_supervisor_bench.sv]
// Self-checking bench of the run-permit fault supervisor
`timescale 1ns/1ps
`include "lrpfs_regs.vh"
module lrpfs_supervisor_bench;
    logic        clk, arst_n, tempFaultIn, shutterFaultIn, reflOverIn, terminalFaultIn, avs_read, avs_write;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, rd;
    wire         modIn, permitIn, laserOut, sysFault, dutyExcessFlag, reflectionExcessFlag;
    wire         tempFaultFlag, shutterFaultFlag, irq, avs_waitrequest;
    wire  [31:0] avs_readdata;
    int          errors, n_compared, laserCnt, dutyCnt, reflCnt;

    lrpfs_ctrl_model ctrl (.clk(clk), .modIn(modIn), .permitIn(permitIn));
    lrpfs_supervisor DUT (.clk(clk), .arst_n(arst_n), .modIn(modIn), .permitIn(permitIn),
        .tempFaultIn(tempFaultIn), .shutterFaultIn(shutterFaultIn), .reflOverIn(reflOverIn),
        .terminalFaultIn(terminalFaultIn), .laserOut(laserOut), .sysFault(sysFault),
        .dutyExcessFlag(dutyExcessFlag), .reflectionExcessFlag(reflectionExcessFlag),
        .tempFaultFlag(tempFaultFlag), .shutterFaultFlag(shutterFaultFlag), .irq(irq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycle counts of the outputs during one pulse
    always @(posedge clk) begin
        if (laserOut === 1'b1) laserCnt++;
        if (dutyExcessFlag === 1'b1) dutyCnt++;
        if (reflectionExcessFlag === 1'b1) reflCnt++;
    end

    task automatic test_done();
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low, only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic pulse_chk(input int w, input int el, input int ed, input int er);
        laserCnt = 0;
        dutyCnt = 0;
        reflCnt = 0;
        ctrl.pulse(w);
        chk(laserCnt, el);
        chk(dutyCnt, ed);
        chk(reflCnt, er);
    endtask

    // Reset held 12 cycles, then room for the power-up check
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (30) @(posedge clk);
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end

    initial begin
        {arst_n, tempFaultIn, shutterFaultIn, reflOverIn, terminalFaultIn, avs_read, avs_write} = 7'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        do_reset();
        rchk(`LRPFS_OFF_CTRL, 32'h0000_0001);
        rchk(`LRPFS_OFF_PW_LIMIT, 32'h0000_2710);
        rchk(`LRPFS_OFF_DUTY_LIMIT, 32'h0000_0200);
        rchk(`LRPFS_OFF_IRQ_EN, 32'h0000_0000);
        rchk(5'h1C, 32'h0000_0000);
        rchk(`LRPFS_OFF_STATUS, 32'h0000_0180);
        pulse_chk(10, 10, 0, 0);
        bus(1'b1, `LRPFS_OFF_PW_LIMIT, 32'h0000_0005);
        pulse_chk(10, 5, 5, 0);
        bus(1'b1, `LRPFS_OFF_PW_LIMIT, 32'h0000_2710);
        // A zero duty budget inhibits the whole pulse whatever the window phase
        bus(1'b1, `LRPFS_OFF_DUTY_LIMIT, 32'h0000_0000);
        rchk(`LRPFS_OFF_DUTY_LIMIT, 32'h0000_0000);
        pulse_chk(10, 0, 10, 0);
        bus(1'b1, `LRPFS_OFF_DUTY_LIMIT, 32'h0000_0200);
        reflOverIn <= 1'b1;
        pulse_chk(10, 0, 0, 10);
        reflOverIn <= 1'b0;
        pulse_chk(10, 10, 0, 0);
        rchk(`LRPFS_OFF_IRQ_STAT, 32'h0000_0003);
        chk(irq, 1'b0);
        bus(1'b1, `LRPFS_OFF_IRQ_EN, 32'h0000_0002);
        @(posedge clk);
        chk(irq, 1'b1);
        bus(1'b1, `LRPFS_OFF_IRQ_CLR, 32'h0000_0002);
        @(posedge clk);
        chk(irq, 1'b0);
        rchk(`LRPFS_OFF_IRQ_STAT, 32'h0000_0001);
        bus(1'b1, `LRPFS_OFF_IRQ_CLR, 32'h0000_001F);
        bus(1'b1, `LRPFS_OFF_STATUS, 32'h0000_FFFF);
        rchk(`LRPFS_OFF_STATUS, 32'h0000_0180);
        bus(1'b1, `LRPFS_OFF_CTRL, 32'h0000_0000);
        pulse_chk(10, 0, 0, 0);
        bus(1'b1, `LRPFS_OFF_CTRL, 32'h0000_0001);
        ctrl.set_permit(1'b0);
        pulse_chk(10, 0, 0, 0);
        ctrl.set_permit(1'b1);
        // Temperature then shutter: latch, refuse, ignore toggle while present, clear
        for (int i = 0; i < 2; i++) begin
            if (i == 0) tempFaultIn <= 1'b1;
            else shutterFaultIn <= 1'b1;
            repeat (5) @(posedge clk);
            chk({tempFaultFlag, shutterFaultFlag, sysFault}, (i == 0) ? 3'b101 : 3'b011);
            rchk(`LRPFS_OFF_STATUS, (i == 0) ? 32'h0000_01C8 : 32'h0000_01D0);
            ctrl.toggle();
            pulse_chk(10, 0, 0, 0);
            tempFaultIn <= 1'b0;
            shutterFaultIn <= 1'b0;
            repeat (5) @(posedge clk);
            chk(sysFault, 1'b1);
            ctrl.toggle();
            chk(sysFault, 1'b0);
            pulse_chk(10, 10, 0, 0);
            rchk(`LRPFS_OFF_IRQ_STAT, 32'h0000_0014);
            bus(1'b1, `LRPFS_OFF_IRQ_CLR, 32'h0000_001F);
        end
        terminalFaultIn <= 1'b1;
        do_reset();
        chk({sysFault, tempFaultFlag, shutterFaultFlag}, 3'b100);
        pulse_chk(10, 0, 0, 0);
        rchk(`LRPFS_OFF_STATUS, 32'h0000_01E0);
        rchk(`LRPFS_OFF_IRQ_STAT, 32'h0000_0008);
        terminalFaultIn <= 1'b0;
        do_reset();
        pulse_chk(10, 10, 0, 0);
        test_done();
    end
endmodule // lrpfs_supervisor_bench

bind lrpfs_supervisor lrpfs_supervisor_sva chk_i (.clk(clk), .arst_n(arst_n), .modIn(modIn),
    .permitIn(permitIn), .tempFaultIn(tempFaultIn), .shutterFaultIn(shutterFaultIn), .reflOverIn(reflOverIn),
    .laserOut(laserOut), .sysFault(sysFault), .dutyExcessFlag(dutyExcessFlag),
    .reflectionExcessFlag(reflectionExcessFlag), .tempFaultFlag(tempFaultFlag),
    .shutterFaultFlag(shutterFaultFlag), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest));
